// ### design/hp_pkg.sv
/*
  Shared constants, state types and helper functions for the host port.
  Assumes a sixteen-bit host data path and a 2M byte chip-select region.
*/
package hp_pkg;

  // ==========================================================================
  // Address window
  localparam int HP_ADDR_W = 21;
  localparam int HP_WORD_W = 16;
  localparam logic [15:0] HP_BUF_LAST = 16'h9FFF;
  localparam logic [15:0] HP_REG_BASE = 16'hFFF0;
  localparam int HP_BUF_WORDS = 40960;
  localparam int HP_REG_WORDS = 16;

  // ==========================================================================
  // Straps and reset values
  localparam logic [2:0] HP_SEL_GENERIC = 3'h7;
  localparam logic HP_BS_GENERIC = 1'h0;
  localparam logic HP_ORDER_LITTLE = 1'h0;
  localparam logic HP_WAIT_RST = 1'h0;
  localparam logic [1:0] HP_OE_N_RST = 2'h3;
  localparam logic [15:0] HP_DATA_RST = 16'h0000;

  // ==========================================================================
  // States and regions
  typedef enum logic [1:0] {HP_RG_BUF, HP_RG_REG, HP_RG_NONE} hp_region_e;
  typedef enum logic [1:0] {HC_IDLE, HC_ARB, HC_RUN, HC_FETCH} hp_core_e;
  typedef enum logic [1:0] {HL_IDLE, HL_BUSY, HL_HOLD} hp_link_e;

  function automatic hp_region_e hp_region(input logic [15:0] waddr);
    if (waddr <= HP_BUF_LAST) begin
      return HP_RG_BUF;
    end else if (waddr >= HP_REG_BASE) begin
      return HP_RG_REG;
    end
    return HP_RG_NONE;
  endfunction : hp_region

  function automatic logic [15:0] hp_swap(input logic [15:0] w,
                                          input logic be);
    return be ? {w[7:0], w[15:8]} : w;
  endfunction : hp_swap

  function automatic logic [1:0] hp_lane_swap(input logic [1:0] l,
                                              input logic be);
    return be ? {l[0], l[1]} : l;
  endfunction : hp_lane_swap

endpackage : hp_pkg

// ### design/hp_xfer_if.sv
/*
  Carrier between the host-clock side and the system-clock side.
  Assumes request and answer cross by toggles with the words held stable.
*/
`timescale 1ns/1ps
interface hp_xfer_if;
  logic req_tgl;
  logic [15:0] waddr;
  logic [15:0] wdata;
  logic [1:0] lanes;
  logic write;
  logic ack_tgl;
  logic [15:0] rdata;
  logic generic;

  modport link (output req_tgl, output waddr, output wdata, output lanes,
                output write, input ack_tgl, input rdata, input generic);
  modport core (input req_tgl, input waddr, input wdata, input lanes,
                input write, output ack_tgl, output rdata, output generic);
endinterface : hp_xfer_if

// ### design/hp_sync2.sv
/*
  Two flip-flop synchroniser for levels and toggles.
  Assumes the input changes no faster than the destination can sample it.
*/
`timescale 1ns/1ps
module hp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hp_sync_s;

  hp_sync_s r_q;
  hp_sync_s r_d;

  always_comb begin
    r_d.s1 = d_i;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q_o = r_q.s2;
endmodule : hp_sync2

// ### design/hp_link.sv
/*
  Host-clock side of the port: strobe decode, wait and data pin drive.
  Assumes host pins are synchronous to the host port clock.
*/
`timescale 1ns/1ps
module hp_link
  import hp_pkg::*;
(
  input wire logic host_port_clock_i,
  input wire logic reset_n_i,
  input wire logic chip_select_n_i,
  input wire logic [HP_ADDR_W-1:0] host_addr_in_i,
  input wire logic [15:0] host_data_in_i,
  input wire logic low_byte_read_strobe_n_i,
  input wire logic high_byte_read_strobe_n_i,
  input wire logic low_byte_write_strobe_n_i,
  input wire logic high_byte_write_strobe_n_i,
  output logic [15:0] host_data_out_o,
  output logic [1:0] host_data_oe_n_o,
  output logic wait_n_o,
  hp_xfer_if.link x
);
  typedef struct packed {
    hp_link_e st;
    logic req_tgl;
    logic [15:0] waddr;
    logic [15:0] wdata;
    logic [1:0] lanes;
    logic write;
    logic ack_seen;
    logic wait_n;
    logic [15:0] dout;
    logic [1:0] oe_n;
  } hp_link_s;

  hp_link_s r_q;
  hp_link_s r_d;
  logic ack_s;
  logic generic_s;
  logic [1:0] rd_lanes;
  logic [1:0] wr_lanes;

  hp_sync2 #(.W(2)) u_sync (
    .clk_i(host_port_clock_i),
    .reset_n_i(reset_n_i),
    .d_i({x.ack_tgl, x.generic}),
    .q_o({ack_s, generic_s})
  );

  assign rd_lanes = ~{high_byte_read_strobe_n_i, low_byte_read_strobe_n_i};
  assign wr_lanes = ~{high_byte_write_strobe_n_i, low_byte_write_strobe_n_i};

  // ==========================================================================
  // Access sequence
  always_comb begin
    r_d = r_q;
    case (r_q.st)
      HL_IDLE: begin
        if (!chip_select_n_i && generic_s && |(rd_lanes | wr_lanes)) begin
          r_d.waddr = host_addr_in_i[16:1];
          r_d.wdata = host_data_in_i;
          r_d.write = |wr_lanes;
          r_d.lanes = (|wr_lanes) ? wr_lanes : rd_lanes;
          r_d.req_tgl = ~r_q.req_tgl;
          r_d.st = HL_BUSY;
        end
      end
      HL_BUSY: begin
        if (ack_s != r_q.ack_seen) begin
          r_d.ack_seen = ack_s;
          r_d.wait_n = 1'h1;
          if (!r_q.write) begin
            r_d.dout = x.rdata;
            r_d.oe_n = ~r_q.lanes;
          end
          r_d.st = HL_HOLD;
        end
      end
      HL_HOLD: begin
        // The release waits for the strobes or chip select to rise so one access ends in one ack.
        if (chip_select_n_i || !(|(rd_lanes | wr_lanes))) begin
          r_d.wait_n = HP_WAIT_RST;
          r_d.oe_n = HP_OE_N_RST;
          r_d.st = HL_IDLE;
        end
      end
      default: begin
        r_d.st = HL_IDLE;
      end
    endcase
  end

  always_ff @(posedge host_port_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_q <= '{st: HL_IDLE, req_tgl: 1'h0, waddr: 16'h0000,
               wdata: HP_DATA_RST, lanes: 2'h0, write: 1'h0,
               ack_seen: 1'h0, wait_n: HP_WAIT_RST, dout: HP_DATA_RST,
               oe_n: HP_OE_N_RST};
    end else begin
      r_q <= r_d;
    end
  end

  assign x.req_tgl = r_q.req_tgl;
  assign x.waddr = r_q.waddr;
  assign x.wdata = r_q.wdata;
  assign x.lanes = r_q.lanes;
  assign x.write = r_q.write;
  assign host_data_out_o = r_q.dout;
  assign host_data_oe_n_o = r_q.oe_n;
  assign wait_n_o = r_q.wait_n;
endmodule : hp_link

// ### design/hp_port_top.sv
/*
  Sixteen-bit generic host port with its display buffer and register file.
  Assumes the host port clock comes from the host system clock and that
  display refresh requests arrive as a level on the system clock.
*/
`timescale 1ns/1ps

module hp_port_top
  import hp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic host_port_clock_i,
  input wire logic chip_select_n_i,
  input wire logic [HP_ADDR_W-1:0] host_addr_in_i,
  input wire logic [15:0] host_data_in_i,
  output logic [15:0] host_data_out_o,
  output logic [1:0] host_data_oe_n_o,
  input wire logic low_byte_read_strobe_n_i,
  input wire logic high_byte_read_strobe_n_i,
  input wire logic low_byte_write_strobe_n_i,
  input wire logic high_byte_write_strobe_n_i,
  output logic wait_n_o,
  input wire logic bus_select_strap_a_i,
  input wire logic bus_select_strap_b_i,
  input wire logic bus_select_strap_c_i,
  input wire logic byte_order_strap_i,
  input wire logic bus_status_strap_n_i,
  input wire logic refresh_req_i,
  output logic host_grant_o,
  output logic generic_mode_o,
  output logic big_endian_o
);

  // ==========================================================================
  // Core state
  typedef struct packed {
    hp_core_e st;
    logic req_seen;
    logic strap_done;
    logic generic;
    logic big_endian;
    logic grant;
    logic ack_tgl;
    logic [15:0] rdata;
    logic [15:0] waddr;
    logic [15:0] wdata;
    logic [1:0] lanes;
    logic write;
    hp_region_e region;
  } hp_core_s;

  hp_core_s r_q;
  hp_core_s r_d;

  logic [HP_WORD_W-1:0] buf_rd;
  logic [HP_WORD_W-1:0] reg_rd;
  logic req_s;
  logic [4:0] strap_s;
  logic do_write;
  logic [15:0] mem_wdata;
  logic [1:0] mem_lanes;
  logic [15:0] buf_idx;
  logic [3:0] reg_idx;

  hp_xfer_if x ();

  // ==========================================================================
  // Host clock side
  hp_link u_link (
    .host_port_clock_i(host_port_clock_i),
    .reset_n_i(reset_n_i),
    .chip_select_n_i(chip_select_n_i),
    .host_addr_in_i(host_addr_in_i),
    .host_data_in_i(host_data_in_i),
    .low_byte_read_strobe_n_i(low_byte_read_strobe_n_i),
    .high_byte_read_strobe_n_i(high_byte_read_strobe_n_i),
    .low_byte_write_strobe_n_i(low_byte_write_strobe_n_i),
    .high_byte_write_strobe_n_i(high_byte_write_strobe_n_i),
    .host_data_out_o(host_data_out_o),
    .host_data_oe_n_o(host_data_oe_n_o),
    .wait_n_o(wait_n_o),
    .x(x.link)
  );

  // ==========================================================================
  // Crossings into the system clock
  hp_sync2 #(.W(1)) u_req_sync (
    .clk_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .d_i(x.req_tgl),
    .q_o(req_s)
  );

  // The strap stages stay out of reset, so at release they already hold
  // the levels that stood on the strap pins while reset was low.
  hp_sync2 #(.W(5)) u_strap_sync (
    .clk_i(clk_sys_i),
    .reset_n_i(1'b1),
    .d_i({bus_select_strap_c_i, bus_select_strap_b_i,
          bus_select_strap_a_i, bus_status_strap_n_i, byte_order_strap_i}),
    .q_o(strap_s)
  );

  // ==========================================================================
  // Arbitration and access sequence
  always_comb begin
    r_d = r_q;
    if (!r_q.strap_done) begin
      // First edge after release: take the straps as they stood in reset.
      r_d.strap_done = 1'h1;
      r_d.generic = (strap_s[4:2] == HP_SEL_GENERIC) &&
                    (strap_s[1] == HP_BS_GENERIC);
      r_d.big_endian = (strap_s[0] != HP_ORDER_LITTLE);
    end
    case (r_q.st)
      HC_IDLE: begin
        if (req_s != r_q.req_seen) begin
          r_d.req_seen = req_s;
          r_d.waddr = x.waddr;
          r_d.wdata = hp_swap(x.wdata, r_q.big_endian);
          r_d.lanes = hp_lane_swap(x.lanes, r_q.big_endian);
          r_d.write = x.write;
          r_d.region = hp_region(x.waddr);
          r_d.st = HC_ARB;
        end
      end
      HC_ARB: begin
        // Refresh keeps priority; the host waits for a quiet cycle.
        if (!refresh_req_i) begin
          r_d.grant = 1'h1;
          r_d.st = HC_RUN;
        end
      end
      HC_RUN: begin
        r_d.st = HC_FETCH;
      end
      HC_FETCH: begin
        if (r_q.write) begin
          r_d.rdata = r_q.rdata;
        end else if (r_q.region == HP_RG_BUF) begin
          r_d.rdata = hp_swap(buf_rd, r_q.big_endian);
        end else if (r_q.region == HP_RG_REG) begin
          r_d.rdata = hp_swap(reg_rd, r_q.big_endian);
        end else begin
          r_d.rdata = HP_DATA_RST;
        end
        r_d.grant = 1'h0;
        r_d.ack_tgl = ~r_q.ack_tgl;
        r_d.st = HC_IDLE;
      end
      default: begin
        r_d.st = HC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_q <= '{st: HC_IDLE, req_seen: 1'h0, strap_done: 1'h0,
               generic: 1'h0, big_endian: HP_ORDER_LITTLE, grant: 1'h0,
               ack_tgl: 1'h0, rdata: HP_DATA_RST, waddr: 16'h0000,
               wdata: HP_DATA_RST, lanes: 2'h0, write: 1'h0,
               region: HP_RG_NONE};
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================================
  // Buffer and register storage
  assign do_write = (r_q.st == HC_RUN) && r_q.write;
  assign mem_wdata = r_q.wdata;
  assign mem_lanes = r_q.lanes;
  assign buf_idx = r_q.waddr;
  assign reg_idx = r_q.waddr[3:0];

  // Each lane keeps a byte array of its own, so a masked write leaves the
  // other lane alone and every array has exactly one writer.
  // Only lanes whose strobe was low are written; unmapped words drop.
  for (genvar i = 0; i < 2; i++) begin : g_lane
    logic [7:0] buf_lane [HP_BUF_WORDS];
    logic [7:0] reg_lane [HP_REG_WORDS];
    logic [7:0] buf_byte_q;
    logic [7:0] reg_byte_q;

    always_ff @(posedge clk_sys_i) begin
      if (do_write && mem_lanes[i]) begin
        if (r_q.region == HP_RG_BUF) begin
          buf_lane[buf_idx] <= mem_wdata[i*8 +: 8];
        end
        if (r_q.region == HP_RG_REG) begin
          reg_lane[reg_idx] <= mem_wdata[i*8 +: 8];
        end
      end
      if (r_q.st == HC_RUN && r_q.region == HP_RG_BUF) begin
        buf_byte_q <= buf_lane[buf_idx];
      end
      if (r_q.st == HC_RUN) begin
        reg_byte_q <= reg_lane[reg_idx];
      end
    end
  end

  assign buf_rd = {g_lane[1].buf_byte_q, g_lane[0].buf_byte_q};
  assign reg_rd = {g_lane[1].reg_byte_q, g_lane[0].reg_byte_q};

  // ==========================================================================
  // Answers back to the host clock side, and the grant and mode pins
  assign x.ack_tgl = r_q.ack_tgl;
  assign x.rdata = r_q.rdata;
  assign x.generic = r_q.generic;
  assign host_grant_o = r_q.grant;
  assign generic_mode_o = r_q.generic;
  assign big_endian_o = r_q.big_endian;

endmodule : hp_port_top

// ### bench/hp_port_asserts.sv
/*
  Assertions on the host port top pins in the host clock domain; the
  latched mode outputs are checked on the system clock that drives them.
  Assumes it is attached by a bind in the bench top.
*/
`timescale 1ns/1ps
module hp_port_asserts (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic host_port_clock_i,
  input wire logic chip_select_n_i,
  input wire logic [1:0] host_data_oe_n_o,
  input wire logic low_byte_read_strobe_n_i,
  input wire logic high_byte_read_strobe_n_i,
  input wire logic low_byte_write_strobe_n_i,
  input wire logic high_byte_write_strobe_n_i,
  input wire logic wait_n_o,
  input wire logic generic_mode_o,
  input wire logic big_endian_o
);
  // ==========================================================================
  // Helpers
  logic up;
  assign up = low_byte_read_strobe_n_i & high_byte_read_strobe_n_i &
              low_byte_write_strobe_n_i & high_byte_write_strobe_n_i;
  default clocking cb @(posedge host_port_clock_i);
  endclocking
  default disable iff (!reset_n_i);

  // ==========================================================================
  // Properties
  chk_lane_read: assert property (
    !host_data_oe_n_o[0] |-> !$past(low_byte_read_strobe_n_i) ||
      !$past(low_byte_read_strobe_n_i, 2))
    else $error("low lane driven without a read");
  chk_lane_write: assert property (
    !low_byte_write_strobe_n_i [*3] |-> host_data_oe_n_o == 2'h3)
    else $error("lanes driven during a write");
  chk_wait_mode: assert property (
    wait_n_o |-> generic_mode_o)
    else $error("access completed outside generic mode");
  chk_wait_cause: assert property (
    $rose(wait_n_o) |-> !chip_select_n_i && !up)
    else $error("wait released with no access");
  chk_wait_stay: assert property (
    wait_n_o && !up && !chip_select_n_i |=> wait_n_o)
    else $error("wait fell before strobes rose");
  chk_wait_end: assert property (
    wait_n_o && (up || chip_select_n_i) |=> !wait_n_o)
    else $error("wait held after strobes rose");
  chk_wait_min: assert property (
    $fell(up) && !chip_select_n_i |-> !wait_n_o [*3])
    else $error("wait released too early");
  chk_straps_held: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $past(reset_n_i, 3) |-> $stable(generic_mode_o) && $stable(big_endian_o))
    else $error("latched mode changed");
endmodule : hp_port_asserts

// ### bench/hp_host_model.sv
/*
  Host bus master model: single halfword transfers ended by acknowledge.
  Assumes the acknowledge is the inverted wait under chip select.
*/
`timescale 1ns/1ps
module hp_host_model (
  input wire logic host_port_clock_i,
  output logic chip_select_n_o,
  output logic [20:0] host_addr_o,
  output logic [15:0] host_data_o,
  output logic [1:0] read_strobe_n_o,
  output logic [1:0] write_strobe_n_o,
  input wire logic wait_n_i,
  input wire logic [15:0] host_data_i,
  input wire logic [1:0] host_data_oe_n_i
);
  initial begin
    chip_select_n_o = 1'b1;
    host_addr_o = 21'h0;
    host_data_o = 16'h0;
    read_strobe_n_o = 2'h3;
    write_strobe_n_o = 2'h3;
  end

  // ==========================================================================
  // Transfer
  // Released lines flip so a stale value can never look valid.
  task automatic access(input logic wr, input logic [1:0] ln,
                        input logic [20:0] a, input logic [15:0] d,
                        input int lim, output logic [15:0] q,
                        output logic ok);
    ok = 1'b0;
    @(posedge host_port_clock_i);
    #1;
    chip_select_n_o = 1'b0;
    host_addr_o = a;
    host_data_o = wr ? d : ~host_data_o;
    if (wr) begin
      write_strobe_n_o = ~ln;
    end else begin
      read_strobe_n_o = ~ln;
    end
    for (int n = 0; n < lim && !ok; n++) begin
      @(posedge host_port_clock_i);
      ok = (wait_n_i === 1'b1);
    end
    // A lane the port does not drive reads back inverted: no bus keeper.
    q = {host_data_oe_n_i[1] ? ~host_data_i[15:8] : host_data_i[15:8],
         host_data_oe_n_i[0] ? ~host_data_i[7:0] : host_data_i[7:0]};
    #1;
    chip_select_n_o = 1'b1;
    read_strobe_n_o = 2'h3;
    write_strobe_n_o = 2'h3;
    host_data_o = ~host_data_o;
    host_addr_o = ~host_addr_o;
    for (int n = 0; n < 8 && wait_n_i !== 1'b0; n++) begin
      @(posedge host_port_clock_i);
      #1;
    end
  endtask : access
endmodule : hp_host_model

// ### bench/tb_top.sv
/*
  Bench top for the host port: resets with straps, random and corner
  accesses. Assumes the host model drives every host pin.
*/
`timescale 1ns/1ps
module tb_top;
  import hp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic host_clk = 1'b0;
  logic reset_n = 1'b0;
  logic refresh = 1'b0;
  logic [4:0] straps = 5'h07;
  logic cs_n, wait_n, grant, gen, be, ok;
  logic [20:0] addr;
  logic [15:0] din, dout, q;
  logic [1:0] oe_n, rd_n, wr_n;
  logic [15:0] mem [logic [15:0]];
  logic [15:0] corner [4] = '{16'h0000, 16'h9FFF, 16'hFFF0, 16'hFFFF};
  integer seed = 23;
  int miscompares = 0;
  int total_checks = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  always #24 host_clk = ~host_clk;

  hp_port_top u_hp_port_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n),
    .host_port_clock_i(host_clk), .chip_select_n_i(cs_n),
    .host_addr_in_i(addr), .host_data_in_i(din), .host_data_out_o(dout),
    .host_data_oe_n_o(oe_n), .low_byte_read_strobe_n_i(rd_n[0]),
    .high_byte_read_strobe_n_i(rd_n[1]),
    .low_byte_write_strobe_n_i(wr_n[0]),
    .high_byte_write_strobe_n_i(wr_n[1]), .wait_n_o(wait_n),
    .bus_select_strap_a_i(straps[0]), .bus_select_strap_b_i(straps[1]),
    .bus_select_strap_c_i(straps[2]), .byte_order_strap_i(straps[3]),
    .bus_status_strap_n_i(straps[4]), .refresh_req_i(refresh),
    .host_grant_o(grant), .generic_mode_o(gen), .big_endian_o(be));
  hp_host_model u_hp_host_model (.host_port_clock_i(host_clk),
    .chip_select_n_o(cs_n), .host_addr_o(addr), .host_data_o(din),
    .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .wait_n_i(wait_n),
    .host_data_i(dout), .host_data_oe_n_i(oe_n));

  // ==========================================================================
  // Helpers
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  function automatic logic mapped(input logic [15:0] w);
    return w <= 16'h9FFF || w >= 16'hFFF0;
  endfunction : mapped

  task automatic do_reset(input logic [4:0] s);
    @(posedge host_clk);
    #1;
    reset_n = 1'b0;
    straps = s;
    mem.delete();
    repeat (2) @(posedge host_clk);
    #1 reset_n = 1'b1;
    repeat (6) @(posedge host_clk);
    check("generic", {15'h0, gen}, {15'h0, s[2:0] == 3'h7 && !s[4]});
    check("order", {15'h0, be}, {15'h0, s[3]});
  endtask : do_reset

  task automatic wr(input logic [1:0] ln, input logic [15:0] w,
                    input logic [15:0] d, input logic [3:0] al);
    logic [15:0] o;
    u_hp_host_model.access(1'b1, ln, {al, w, 1'b0}, d, 300, q, ok);
    check("write done", {15'h0, ok}, 16'h0001);
    o = mem.exists(w) ? mem[w] : 16'h0000;
    if (mapped(w)) begin
      mem[w] = {ln[1] ? d[15:8] : o[15:8], ln[0] ? d[7:0] : o[7:0]};
    end
  endtask : wr

  task automatic rd(input logic [1:0] ln, input logic [15:0] w,
                    input logic [3:0] al, input string what);
    logic [15:0] m;
    logic [15:0] e;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    e = mapped(w) ? mem[w] : 16'h0000;
    u_hp_host_model.access(1'b0, ln, {al, w, 1'b0}, 16'h0, 300, q, ok);
    check("read done", {15'h0, ok}, 16'h0001);
    check(what, q & m, e & m);
  endtask : rd

  // Full write first, so a partial write never meets unknown old bytes.
  task automatic run_rand(input int n);
    logic [31:0] r1;
    logic [31:0] r2;
    logic [15:0] w;
    logic [1:0] ln;
    for (int i = 0; i < n; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      w = r1[0] ? {12'hFFF, r1[4:1]} : r1[15:0] % 16'hA000;
      if (i < 4) begin
        w = corner[i];
      end
      ln = (r1[17:16] == 2'h0) ? 2'h1 : r1[17:16];
      wr(2'h3, w, r2[15:0], r1[21:18]);
      wr(ln, w, r2[31:16], r1[25:22]);
      ln = (r1[27:26] == 2'h0) ? 2'h3 : r1[27:26];
      rd(ln, w, r1[31:28], "read back");
    end
  endtask : run_rand

  // ==========================================================================
  // Sequence
  initial begin
    do_reset(5'h07);
    run_rand(24);
    wr(2'h3, 16'hA000, 16'h5A5A, 4'h0);
    rd(2'h3, 16'hA000, 4'h2, "unmapped low");
    wr(2'h3, 16'hFFEF, 16'hA5A5, 4'h0);
    rd(2'h3, 16'hFFEF, 4'h3, "unmapped high");
    $display("test little endian done");
    wr(2'h3, 16'h0100, 16'hC3A5, 4'h0);
    @(posedge clk_sys_i);
    #1 refresh = 1'b1;
    fork
      rd(2'h3, 16'h0100, 4'h1, "stalled read");
      begin
        repeat (30) @(posedge host_clk);
        #2;
        check("stall wait", {15'h0, wait_n}, 16'h0000);
        check("stall grant", {15'h0, grant}, 16'h0000);
        @(posedge clk_sys_i);
        #1 refresh = 1'b0;
      end
    join
    $display("test refresh done");
    straps = 5'h18;
    repeat (10) @(posedge host_clk);
    check("held generic", {15'h0, gen}, 16'h0001);
    check("held order", {15'h0, be}, 16'h0000);
    do_reset(5'h0F);
    run_rand(12);
    $display("test big endian done");
    do_reset(5'h06);
    u_hp_host_model.access(1'b0, 2'h3, 21'h0, 16'h0, 20, q, ok);
    check("refused", {15'h0, ok}, 16'h0000);
    do_reset(5'h17);
    u_hp_host_model.access(1'b1, 2'h3, 21'h0, 16'h1, 20, q, ok);
    check("refused", {15'h0, ok}, 16'h0000);
    $display("test modes done");
    finish_test();
  end

  // The run needs well under a tenth of this span.
  initial begin
    #800000;
    miscompares++;
    finish_test();
  end
endmodule : tb_top

bind hp_port_top hp_port_asserts u_hp_port_asserts (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .host_port_clock_i(host_port_clock_i), .chip_select_n_i(chip_select_n_i),
  .host_data_oe_n_o(host_data_oe_n_o),
  .low_byte_read_strobe_n_i(low_byte_read_strobe_n_i),
  .high_byte_read_strobe_n_i(high_byte_read_strobe_n_i),
  .low_byte_write_strobe_n_i(low_byte_write_strobe_n_i),
  .high_byte_write_strobe_n_i(high_byte_write_strobe_n_i),
  .wait_n_o(wait_n_o), .generic_mode_o(generic_mode_o),
  .big_endian_o(big_endian_o));
